// ==== rtl/dpm_consts.svh ====
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define DPM_CLK_NS       8
`define DPM_SEC_NS       1000000000
`define DPM_SECS_PER_INT 12'd3600
`define DPM_HIST_DEPTH   24
`define DPM_CONSEC_RUN   4'd10
`define DPM_SES_RATIO    32'd1000
`define DPM_CNT_MAX      16'hffff
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DPM_REG_CTRL     6'h00
`define DPM_REG_TEST_PND 6'h04
`define DPM_REG_TEST_APP 6'h08
`define DPM_REG_HSEL     6'h0c
`define DPM_REG_CUR0     6'h10
`define DPM_REG_TOT0     6'h1c
`define DPM_REG_HIST0    6'h28
`define DPM_REG_STATUS   6'h34
// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define DPM_CTRL_MODE_LO 0
`define DPM_CTRL_SECPR   2
`define DPM_CTRL_CLEAR   3
`define DPM_CTRL_REFRESH 4
`define DPM_CTRL_SAVE    5
`define DPM_CTRL_UNDO    6
`define DPM_CTRL_INJECT  7
`define DPM_LFSR_SEED    20'h00001
`endif

// ==== rtl/dpm_monitor.sv ====
`timescale 1ns/1ps
`include "dpm_consts.svh"
// Overview of operation
// - Statistics gather only with voting or check correction selected.
// - Check mode: detect errors via check flags, count, repair before four-wire side.
// - Every detected network-side error counts as input error.
// - Check mode: unrepairable errors also count as output errors.
// - Voting mode: output counters are not maintained.
// - Keep twenty-four hourly intervals plus totals over them.
// - Input errored second: any input error that second.
// - Input severe second: errored bits above one per thousand.
// - Input consecutive count arms after ten severe, stops after ten clean.
// - Check mode: count output errored and severe seconds.
// - Output consecutive count arms after ten severe, stops after ten clean.
// - Seven test patterns, default off.
// - Inject exactly one bit error on command.
// - Pending settings kept apart; undo restores last saved.
// - Current and total statistics shown as snapshot taken on refresh; history read live.
// - Direction network by default, or user.
// - Channel primary by default; secondary only if present.
// - Secondary channel rides in bit eight of the byte.
module dpm_monitor #(
  parameter int TICK_CYCLES = `DPM_SEC_NS / `DPM_CLK_NS
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [5:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  input  wire dpm_pkg::dpm_net_word_t net_in,
  output logic      [7:0]            dsu_data,
  output logic                       dsu_valid,
  input  wire logic                  test_strobe,
  output logic                       test_bit,
  output logic                       test_to_net,
  output logic                       test_to_user,
  output logic                       test_on_sec
);
  localparam int NC = 6;  // ies, input_severe_error_seconds, input_consecutive_severe_seconds, oes, output_severe_error_seconds, output_consecutive_severe_seconds
  localparam int HD = `DPM_HIST_DEPTH;

  function automatic logic [15:0] sat_inc(logic [15:0] v, logic en);
    sat_inc = (en && v != `DPM_CNT_MAX) ? v + 16'h0001 : v;
  endfunction
  function automatic logic [3:0] ones8(logic [7:0] v);
    ones8 = 4'h0;
    for (int i = 0; i < 8; i++) ones8 = ones8 + {3'h0, v[i]};
  endfunction

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  dpm_pkg::dpm_corr_t    mode;
  logic                  sec_present;
  dpm_pkg::dpm_test_cfg_t pend, appl;
  logic [4:0]            hsel;
  logic                  rd_ack;
  logic                  wr_ctrl, cmd_clr, cmd_ref, cmd_save, cmd_undo, cmd_inj;
  logic [15:0]           cnt [NC];
  logic [15:0]           tot [NC];
  logic [15:0]           snap_cnt [NC];
  logic [15:0]           snap_tot [NC];
  logic [15:0]           hist [HD][NC];
  logic [4:0]            wp;
  dpm_pkg::dpm_cs_t      cs [2];
  logic [31:0]           rmux;

  // Reads take one wait cycle so read data come from a flop
  assign waitrequest = read && !rd_ack;
  assign wr_ctrl  = write && address == `DPM_REG_CTRL;
  assign cmd_clr  = wr_ctrl && writedata[`DPM_CTRL_CLEAR];
  assign cmd_ref  = wr_ctrl && writedata[`DPM_CTRL_REFRESH];
  assign cmd_save = wr_ctrl && writedata[`DPM_CTRL_SAVE];
  assign cmd_undo = wr_ctrl && writedata[`DPM_CTRL_UNDO];
  assign cmd_inj  = wr_ctrl && writedata[`DPM_CTRL_INJECT];

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ack   <= 1'b0;
      readdata <= 32'h0;
    end else begin
      rd_ack <= read && !rd_ack;
      if (read && !rd_ack) readdata <= rmux;
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rmux = 32'h0;
    unique case (address)
      `DPM_REG_CTRL:     rmux = {29'h0, sec_present, mode};
      `DPM_REG_TEST_PND: rmux = {27'h0, pend};
      `DPM_REG_TEST_APP: rmux = {27'h0, appl};
      `DPM_REG_HSEL:     rmux = {27'h0, hsel};
      `DPM_REG_STATUS:   rmux = {25'h0, cs[1], cs[0], wp};
      default: begin
        for (int w = 0; w < 3; w++) begin
          if (address == `DPM_REG_CUR0 + 6'(4 * w))
            rmux = {snap_cnt[2*w+1], snap_cnt[2*w]};
          if (address == `DPM_REG_TOT0 + 6'(4 * w))
            rmux = {snap_tot[2*w+1], snap_tot[2*w]};
          if (address == `DPM_REG_HIST0 + 6'(4 * w) && hsel < 5'(HD))
            rmux = {hist[hsel][2*w+1], hist[hsel][2*w]};
        end
      end
    endcase
  end

  // Mode, presence of the secondary channel and history select
  always_ff @(posedge clk) begin
    if (rst) begin
      mode        <= dpm_pkg::DPM_CORR_OFF;
      sec_present <= 1'b0;
      hsel        <= 5'h0;
    end else begin
      if (wr_ctrl) begin
        mode        <= dpm_pkg::dpm_corr_t'(writedata[`DPM_CTRL_MODE_LO +: 2]);
        sec_present <= writedata[`DPM_CTRL_SECPR];
      end
      if (write && address == `DPM_REG_HSEL) hsel <= writedata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend <= '{dpm_pkg::DPM_PAT_OFF, 1'b0, 1'b0};
      appl <= '{dpm_pkg::DPM_PAT_OFF, 1'b0, 1'b0};
    end else begin
      if (write && address == `DPM_REG_TEST_PND) begin
        pend.pattern  <= dpm_pkg::dpm_pat_t'(writedata[4:2]);
        pend.dir_user <= writedata[1];
        pend.chan_sec <= writedata[0] && sec_present;
      end else if (cmd_undo) begin
        pend <= appl;
      end else if (!sec_present) begin
        pend.chan_sec <= 1'b0;
      end
      if (cmd_save) appl <= pend;
      else if (!sec_present) appl.chan_sec <= 1'b0;
    end
  end

  // ----------------------------------------
  // Network side correction
  // ----------------------------------------
  logic [7:0] maj_byte, maj_diff, in_mask;
  logic [3:0] in_bits, out_bits;
  logic       gather;
  assign maj_byte = (net_in.copy_a & net_in.copy_b) | (net_in.copy_a & net_in.copy_c) |
                    (net_in.copy_b & net_in.copy_c);
  assign maj_diff = (net_in.copy_a ^ net_in.copy_b) | (net_in.copy_a ^ net_in.copy_c);
  assign gather   = net_in.valid && mode != dpm_pkg::DPM_CORR_OFF;
  assign in_mask  = (mode == dpm_pkg::DPM_CORR_MAJ) ? maj_diff :
                    (net_in.uncorr ? 8'hff : net_in.fix_mask);
  assign in_bits  = gather ? ones8(in_mask) : 4'h0;
  assign out_bits = (gather && mode == dpm_pkg::DPM_CORR_BCH && net_in.uncorr) ? 4'h8 : 4'h0;

  // Corrected byte toward the four-wire side
  always_ff @(posedge clk) begin
    if (rst) begin
      dsu_data  <= 8'h0;
      dsu_valid <= 1'b0;
    end else begin
      dsu_valid <= net_in.valid;
      unique case (mode)
        dpm_pkg::DPM_CORR_MAJ: dsu_data <= maj_byte;
        dpm_pkg::DPM_CORR_BCH: dsu_data <= net_in.copy_a ^ net_in.fix_mask;
        default:               dsu_data <= net_in.copy_a;
      endcase
      if (sec_present)
        dsu_data[7] <= (test_on_sec && test_to_user) ? test_bit : net_in.sec_bit;
    end
  end

  // ----------------------------------------
  // One-second evaluation
  // ----------------------------------------
  logic [26:0] div;
  logic        tick;
  // Wide enough for a full second of bytes at the real tick rate
  logic [29:0] bits_acc;
  logic [29:0] err_acc [2];
  logic [3:0]  sev_run [2];
  logic [3:0]  ok_run [2];
  logic [11:0] sec_in_int;
  logic        es [2];
  logic        ses [2];
  logic        cs_inc [2];
  logic [15:0] next_cnt [NC];

  assign tick = div == 27'(TICK_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (rst) div <= 27'h0;
    else div <= tick ? 27'h0 : div + 27'h1;
  end

  // Per-second bit and error tallies; a byte in the tick cycle opens the next second
  always_ff @(posedge clk) begin
    if (rst || cmd_clr) begin
      bits_acc <= 30'h0;
      err_acc  <= '{30'h0, 30'h0};
    end else begin
      bits_acc   <= (tick ? 30'h0 : bits_acc) + (gather ? 30'h8 : 30'h0);
      err_acc[0] <= (tick ? 30'h0 : err_acc[0]) + {26'h0, in_bits};
      err_acc[1] <= (tick ? 30'h0 : err_acc[1]) + {26'h0, out_bits};
    end
  end

  always_comb begin
    for (int d = 0; d < 2; d++) begin
      es[d]  = err_acc[d] != 30'h0;
      ses[d] = 40'(err_acc[d]) * 40'(`DPM_SES_RATIO) > 40'(bits_acc);
      cs_inc[d] = cs[d] == dpm_pkg::DPM_CS_ARMED && !(!ses[d] && ok_run[d] == 4'd9);
    end
    for (int k = 0; k < NC; k++) begin
      next_cnt[k] = sat_inc(cnt[k], tick && (k < 3 || mode == dpm_pkg::DPM_CORR_BCH) &&
                    mode != dpm_pkg::DPM_CORR_OFF &&
                    ((k % 3 == 0) ? es[k/3] : (k % 3 == 1) ? ses[k/3] : cs_inc[k/3]));
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cmd_clr) begin
      cs      <= '{dpm_pkg::DPM_CS_IDLE, dpm_pkg::DPM_CS_IDLE};
      sev_run <= '{4'h0, 4'h0};
      ok_run  <= '{4'h0, 4'h0};
    end else if (tick) begin
      for (int d = 0; d < 2; d++) begin
        sev_run[d] <= ses[d] ? ((sev_run[d] == `DPM_CONSEC_RUN) ? sev_run[d]
                                : sev_run[d] + 4'h1) : 4'h0;
        ok_run[d]  <= ses[d] ? 4'h0 : ((ok_run[d] == `DPM_CONSEC_RUN) ? ok_run[d]
                                : ok_run[d] + 4'h1);
        unique case (cs[d])
          dpm_pkg::DPM_CS_IDLE:
            if (ses[d] && sev_run[d] == 4'd9) cs[d] <= dpm_pkg::DPM_CS_ARMED;
          dpm_pkg::DPM_CS_ARMED:
            if (!ses[d] && ok_run[d] == 4'd9) cs[d] <= dpm_pkg::DPM_CS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cmd_clr) begin
      sec_in_int <= 12'h0;
      wp         <= 5'h0;
      for (int k = 0; k < NC; k++) begin
        cnt[k] <= 16'h0;
        tot[k] <= 16'h0;
        for (int h = 0; h < HD; h++) hist[h][k] <= 16'h0;
      end
    end else if (tick && sec_in_int == `DPM_SECS_PER_INT - 12'h1) begin
      // Total drops the evicted hour first; saturated totals stay pinned
      sec_in_int <= 12'h0;
      wp         <= (wp == 5'(HD - 1)) ? 5'h0 : wp + 5'h1;
      for (int k = 0; k < NC; k++) begin
        cnt[k]      <= 16'h0;
        hist[wp][k] <= next_cnt[k];
        if (tot[k] != `DPM_CNT_MAX)
          tot[k] <= (17'(tot[k] - hist[wp][k]) + 17'(next_cnt[k]) > 17'h0ffff)
                    ? `DPM_CNT_MAX : tot[k] - hist[wp][k] + next_cnt[k];
      end
    end else begin
      if (tick) sec_in_int <= sec_in_int + 12'h1;
      for (int k = 0; k < NC; k++) cnt[k] <= next_cnt[k];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cmd_clr) begin
      for (int k = 0; k < NC; k++) begin
        snap_cnt[k] <= 16'h0;
        snap_tot[k] <= 16'h0;
      end
    end else if (cmd_ref) begin
      snap_cnt <= cnt;
      snap_tot <= tot;
    end
  end

  // ----------------------------------------
  // Test signal generator
  // ----------------------------------------
  logic [19:0] lfsr;
  logic [2:0]  phase;
  logic        raw, fb, inj_pend, t_on;
  dpm_pkg::dpm_pat_t cur_pat;
  assign t_on = appl.pattern != dpm_pkg::DPM_PAT_OFF;
  always_comb begin
    unique case (appl.pattern)
      dpm_pkg::DPM_PAT_ONES:  raw = 1'b1;
      dpm_pkg::DPM_PAT_ALT:   raw = phase[0];
      dpm_pkg::DPM_PAT_1IN8:  raw = phase == 3'h1;
      dpm_pkg::DPM_PAT_P511, dpm_pkg::DPM_PAT_P2047, dpm_pkg::DPM_PAT_QRSS: raw = lfsr[0];
      default:                raw = 1'b0;
    endcase
    unique case (appl.pattern)
      dpm_pkg::DPM_PAT_P511:  fb = lfsr[8] ^ lfsr[4];
      dpm_pkg::DPM_PAT_P2047: fb = lfsr[10] ^ lfsr[8];
      default:                fb = lfsr[19] ^ lfsr[16];
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr     <= `DPM_LFSR_SEED;
      phase    <= 3'h0;
      cur_pat  <= dpm_pkg::DPM_PAT_OFF;
      inj_pend <= 1'b0;
      test_bit <= 1'b0;
    end else begin
      cur_pat <= appl.pattern;
      if (cur_pat != appl.pattern) begin
        lfsr  <= `DPM_LFSR_SEED;
        phase <= 3'h0;
      end else if (test_strobe) begin
        lfsr  <= {lfsr[18:0], fb};
        phase <= phase + 3'h1;
      end
      if (test_strobe) test_bit <= t_on && (raw ^ inj_pend);
      // Request arriving with the strobe survives to the next bit
      inj_pend <= t_on && (cmd_inj || (inj_pend && !test_strobe));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      test_to_net  <= 1'b0;
      test_to_user <= 1'b0;
      test_on_sec  <= 1'b0;
    end else begin
      test_to_net  <= t_on && !appl.dir_user;
      test_to_user <= t_on && appl.dir_user;
      test_on_sec  <= t_on && appl.chan_sec && sec_present;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_off_quiet;
    mode == dpm_pkg::DPM_CORR_OFF && !cmd_clr &&
      !(tick && sec_in_int == `DPM_SECS_PER_INT - 12'h1) |=>
      $stable(cnt[0]) && $stable(cnt[1]);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("stats moved with correction off");

  property p_bch_fix;
    net_in.valid && mode == dpm_pkg::DPM_CORR_BCH |=>
      dsu_data[6:0] == $past(net_in.copy_a[6:0] ^ net_in.fix_mask[6:0]);
  endproperty
  a_bch_fix: assert property (p_bch_fix) else $error("check repair wrong");

  property p_es_inc;
    tick && es[0] && mode != dpm_pkg::DPM_CORR_OFF && !cmd_clr && cnt[0] < 16'h0ff0 &&
      sec_in_int != `DPM_SECS_PER_INT - 12'h1 |=> cnt[0] == $past(cnt[0]) + 16'h1;
  endproperty
  a_es_inc: assert property (p_es_inc) else $error("errored second missed");

  property p_maj_no_out;
    mode == dpm_pkg::DPM_CORR_MAJ && !cmd_clr |=> $stable(cnt[3]) || cnt[3] == 16'h0;
  endproperty
  a_maj_no_out: assert property (p_maj_no_out) else $error("output count in voting mode");

  property p_arm_in;
    tick && ses[0] && sev_run[0] == 4'd9 && !cmd_clr |=> cs[0] == dpm_pkg::DPM_CS_ARMED;
  endproperty
  a_arm_in: assert property (p_arm_in) else $error("consecutive count did not arm");

  property p_sat;
    cnt[1] == `DPM_CNT_MAX && !cmd_clr &&
      !(tick && sec_in_int == `DPM_SECS_PER_INT - 12'h1) |=> cnt[1] == `DPM_CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped");

  property p_undo;
    cmd_undo && !(write && address == `DPM_REG_TEST_PND) |=> pend == $past(appl);
  endproperty
  a_undo: assert property (p_undo) else $error("undo did not restore");

  property p_snap;
    cmd_ref && !cmd_clr |=> snap_cnt[0] == $past(cnt[0]) ##1
      ($stable(snap_cnt[0]) || $past(cmd_ref) || $past(cmd_clr));
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot not taken");

  property p_sec_only;
    !sec_present |=> !test_on_sec;
  endproperty
  a_sec_only: assert property (p_sec_only) else $error("secondary used without channel");

  property p_clear;
    cmd_clr |=> cnt[0] == 16'h0 && tot[0] == 16'h0 && hist[0][0] == 16'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left statistics");
endmodule // dpm_monitor

// ==== rtl/dpm_pkg.sv ====
package dpm_pkg;
  typedef enum logic [1:0] {
    DPM_CORR_OFF = 2'b00, DPM_CORR_MAJ = 2'b01, DPM_CORR_BCH = 2'b10
  } dpm_corr_t;
  typedef enum logic [2:0] {
    DPM_PAT_OFF = 3'b000, DPM_PAT_ONES = 3'b001, DPM_PAT_ZEROS = 3'b010,
    DPM_PAT_ALT = 3'b011, DPM_PAT_1IN8 = 3'b100, DPM_PAT_P511 = 3'b101,
    DPM_PAT_P2047 = 3'b110, DPM_PAT_QRSS = 3'b111
  } dpm_pat_t;
  typedef enum logic {DPM_CS_IDLE = 1'b0, DPM_CS_ARMED = 1'b1} dpm_cs_t;
  typedef struct packed {
    dpm_pat_t pattern;
    logic     dir_user;  // 0 network, 1 user
    logic     chan_sec;  // 0 primary, 1 secondary
  } dpm_test_cfg_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] copy_a;    // Byte, or first copy in voting mode
    logic [7:0] copy_b;
    logic [7:0] copy_c;
    logic [7:0] fix_mask;  // Bits flagged by the check decoder
    logic       uncorr;    // Check decoder cannot repair this byte
    logic       sec_bit;   // Secondary channel bit from the network side
  } dpm_net_word_t;
endpackage

// ==== verif/dpm_monitor_bench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module dpm_monitor_bench;
  localparam int T = 200;
  logic                   clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
  logic                   test_strobe = 1'b0, exp_v = 1'b0, s;
  logic [5:0]             address = 6'h00;
  logic [31:0]            writedata = 32'h0, rd, lfsr = 32'h4d5d8450;
  logic [31:0]            readdata;
  logic                   waitrequest, dsu_valid, test_bit;
  logic                   test_to_net, test_to_user, test_on_sec;
  logic [7:0]             dsu_data, exp_d, data = 8'h00;
  logic [1:0]             kind = 2'h0;
  dpm_pkg::dpm_net_word_t net_in;
  int err_total = 0, samples_checked = 0, cyc = 0, mode = 0, bits = 0, i, k;
  int cnt[6] = '{default: 0}, snap[6] = '{default: 0};
  int acc[2] = '{0, 0}, run[2] = '{0, 0}, cln[2] = '{0, 0};
  bit arm[2] = '{0, 0};
  bit sec_m = 1'b0;

  always #4 clk = ~clk;

  dpm_net_src dpm_net_src_inst (.clk(clk), .rst(rst), .kind(kind), .data(data),
    .net_in(net_in));
  dpm_monitor #(.TICK_CYCLES(T)) dpm_monitor_inst (.clk(clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .net_in(net_in),
    .dsu_data(dsu_data), .dsu_valid(dsu_valid), .test_strobe(test_strobe),
    .test_bit(test_bit), .test_to_net(test_to_net), .test_to_user(test_to_user),
    .test_on_sec(test_on_sec));

  // Random payload bytes
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  always @(posedge clk) begin
    lfsr <= lfsr_next(lfsr);
    data <= lfsr[7:0];
  end

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  // Second boundary is judged at phase 1, well clear of any error burst
  always @(posedge clk) if (!rst) begin
    cyc++;
    if (exp_v) `CHK("dsu_data", exp_d, dsu_data)
    `CHK("dsu_valid", exp_v, dsu_valid)
    exp_v <= net_in.valid;
    exp_d <= (mode == 2) ? (net_in.copy_a ^ net_in.fix_mask) :
             (mode == 1) ? ((net_in.copy_a & net_in.copy_b) | (net_in.copy_a & net_in.copy_c)
                           | (net_in.copy_b & net_in.copy_c)) : net_in.copy_a;
    // Bit eight follows the network side once the channel is present; tracked from the bus
    if (sec_m) exp_d[7] <= net_in.sec_bit;
    if (write && address == 6'h00) sec_m = writedata[2];
    if (net_in.valid) bits += 8;
    if (mode != 0 && net_in.valid) begin
      acc[0] += (mode == 2) ? (net_in.uncorr ? 8 : $countones(net_in.fix_mask))
        : $countones((net_in.copy_a ^ net_in.copy_b) | (net_in.copy_a ^ net_in.copy_c));
      acc[1] += (mode == 2 && net_in.uncorr) ? 8 : 0;
    end
    if (cyc % T == 1 && cyc > 1) begin
      for (int j = 0; j < 2; j++) if (mode == 2 || (mode == 1 && j == 0)) begin
        if (acc[j] > 0) cnt[3*j]++;
        s = (acc[j] * 1000 > bits);
        if (s) cnt[3*j+1]++;
        if (arm[j]) begin
          cln[j] = s ? 0 : cln[j] + 1;
          if (cln[j] == 10) arm[j] = 0;
          else cnt[3*j+2]++;
        end else begin
          run[j] = s ? run[j] + 1 : 0;
          if (run[j] == 10) begin arm[j] = 1; cln[j] = 0; run[j] = 0; end
        end
      end
      acc = '{0, 0};
      bits = 0;
    end
  end

  // ----------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------
  // Register traffic stays in mid-second so it never straddles a tick
  task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] wd);
    while (cyc % T < 10 || cyc % T > T - 20) @(posedge clk);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  // One second of traffic, errors only away from both boundaries
  task automatic run_sec(input logic [1:0] kk, input bit all);
    while (cyc % T != 2) @(posedge clk);
    for (int n = 0; n < T - 8; n++) begin
      kind <= (n >= 5 && (all || n == T / 2)) ? kk : 2'h0;
      @(posedge clk);
    end
    kind <= 2'h0;
  endtask

  // Refresh, then compare the three count words
  task automatic cmp;
    bus(1, 6'h00, mode | 32'h10);
    snap = cnt;
    for (int j = 0; j < 3; j++) begin
      bus(0, 6'h10 + 6'(4 * j), 32'h0);
      `CHK("count pair", {snap[2*j+1][15:0], snap[2*j][15:0]}, rd)
    end
  endtask

  task automatic strobe(input logic e);
    test_strobe <= 1'b1;
    @(posedge clk);
    test_strobe <= 1'b0;
    @(posedge clk);
    `CHK("test_bit", e, test_bit)
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, well beyond the expected six thousand cycles
  initial begin
    #(8 * 60000);
    err_total++;
    end_of_test;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    bus(0, 6'h04, 32'h0);
    `CHK("pending", 32'h0, rd)
    bus(0, 6'h08, 32'h0);
    `CHK("applied", 32'h0, rd)
    `CHK("to_net", 1'b0, test_to_net)
    // Correction off: errors leave counts at zero
    run_sec(2'h2, 1);
    run_sec(2'h1, 1);
    cmp;
    // Check mode: severe run, clean run, one lone error
    bus(1, 6'h00, 32'h2);
    mode = 2;
    repeat (12) run_sec(2'h2, 1);
    bus(0, 6'h34, 32'h0);
    `CHK("armed", {arm[1], arm[0]}, rd[6:5])
    repeat (10) run_sec(2'h0, 1);
    run_sec(2'h1, 0);
    cmp;
    // Voting mode: output counts frozen
    bus(1, 6'h00, 32'h1);
    mode = 1;
    repeat (3) run_sec(2'h3, 1);
    cmp;
    // Clear wipes every count
    bus(1, 6'h00, 32'h9);
    cnt = '{default: 0};
    arm = '{0, 0};
    run = '{0, 0};
    cln = '{0, 0};
    cmp;
    // Every pattern code; secondary select refused without the channel
    for (k = 0; k < 8; k++) begin
      bus(1, 6'h04, (k << 2) | 3);
      bus(0, 6'h04, 32'h0);
      `CHK("pattern", 32'((k << 2) | 2), rd)
    end
    bus(0, 6'h08, 32'h0);
    `CHK("applied held", 32'h0, rd)
    bus(1, 6'h00, 32'h21);
    bus(0, 6'h08, 32'h0);
    `CHK("saved", 32'h1e, rd)
    `CHK("to_user", 1'b1, test_to_user)
    bus(1, 6'h04, 32'h4);
    bus(1, 6'h00, 32'h41);
    bus(0, 6'h04, 32'h0);
    `CHK("undo", 32'h1e, rd)
    // All-ones pattern with a single injected error
    bus(1, 6'h04, 32'h4);
    bus(1, 6'h00, 32'h21);
    strobe(1'b1);
    bus(1, 6'h00, 32'h81);
    strobe(1'b0);
    strobe(1'b1);
    // Secondary channel present: test attaches to it, bit eight carries the network side
    bus(1, 6'h00, 32'h5);
    bus(1, 6'h04, 32'h5);
    bus(1, 6'h00, 32'h25);
    bus(0, 6'h08, 32'h0);
    `CHK("applied sec", 32'h5, rd)
    `CHK("on_sec", 1'b1, test_on_sec)
    `CHK("to_net sec", 1'b1, test_to_net)
    repeat (8) @(posedge clk);
    end_of_test;
  end
endmodule // dpm_monitor_bench

// ==== verif/dpm_net_src.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Network-side timeslot source
// ----------------------------------------
module dpm_net_src (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [1:0]        kind,
  input  wire logic [7:0]        data,
  output dpm_pkg::dpm_net_word_t net_in
);
  // One byte per cycle; kind 1 flags a bit, 2 is unrepairable, 3 spoils a voting copy
  always_ff @(posedge clk) begin
    if (rst) begin
      net_in <= '0;
    end else begin
      net_in.valid    <= 1'b1;
      net_in.copy_a   <= data;
      net_in.copy_b   <= (kind == 2'h3) ? (data ^ 8'h10) : data;
      net_in.copy_c   <= data;
      net_in.fix_mask <= (kind == 2'h1) ? (8'h01 << data[2:0]) : 8'h00;
      net_in.uncorr   <= (kind == 2'h2);
      net_in.sec_bit  <= ~net_in.sec_bit;  // Keeps moving so a stuck path shows
    end
  end
endmodule // dpm_net_src
